// [rtl/mac_pkg.sv]
// Shared constants and types of the monitor converter configuration block.
package mac_pkg;

    // Register addresses as carried in the six address bits of a command.
    localparam logic [5:0] MAC_REG_GEN_CFG = 6'h00;
    localparam logic [5:0] MAC_REG_CONV_CFG = 6'h01;

    // Reset values of the two configuration words.
    localparam logic [15:0] MAC_GEN_CFG_RST = 16'h0000;
    localparam logic [15:0] MAC_CONV_CFG_RST = 16'hfb68;

    // General configuration field positions.
    localparam int MAC_SOFT_RST_BIT = 15;
    localparam int MAC_ACC_CLR_BIT = 14;
    localparam int MAC_DELAY_MSB = 13;
    localparam int MAC_DELAY_LSB = 6;
    localparam int MAC_COMP_BIT = 5;
    localparam int MAC_RANGE_BIT = 4;
    localparam int MAC_STORED_MSB = 13;
    localparam int MAC_STORED_LSB = 4;
    localparam logic [3:0] MAC_LOW_ZERO = 4'h0;

    // Converter configuration field positions.
    localparam int MAC_MODE_MSB = 15;
    localparam int MAC_MODE_LSB = 12;
    localparam int MAC_CT_LSB[3] = '{9, 6, 3};
    localparam int MAC_CT_W = 3;
    localparam int MAC_AVG_MSB = 2;
    localparam int MAC_AVG_LSB = 0;
    localparam int MAC_CONT_BIT = 3;
    localparam logic [2:0] MAC_NO_CHANNELS = 3'h0;

    // Serial frame layout: command byte then a sixteen-bit data word.
    localparam logic [4:0] MAC_CMD_BITS = 5'h08;
    localparam logic [4:0] MAC_FRAME_BITS = 5'h18;
    localparam int MAC_RW_BIT = 0;
    localparam int MAC_ZERO_BIT = 1;

    // Timing: clock rate, start delay step and the conversion time table.
    localparam int MAC_CLK_MHZ = 50;
    localparam int MAC_DELAY_STEP_MS = 2;
    localparam int MAC_DELAY_STEP_CYCLES = MAC_DELAY_STEP_MS * 1000 * MAC_CLK_MHZ;
    localparam int MAC_CONV_TIME_US[8] = '{50, 84, 150, 280, 540, 1052, 2074, 4120};
    localparam int MAC_TMR_W = 25;

    // Samples averaged per code.
    localparam int MAC_AVG_SAMPLES[8] = '{1, 4, 16, 64, 128, 256, 512, 1024};
    localparam int MAC_AVG_W = 11;

    // Sequencer states, Gray coded along idle, delay, convert, done.
    typedef enum logic [1:0] {
        MAC_ST_IDLE = 2'b00,
        MAC_ST_DELAY = 2'b01,
        MAC_ST_CONV = 2'b11,
        MAC_ST_DONE = 2'b10
    } mac_state_t;

endpackage : mac_pkg

// [rtl/mac_spi_sec.sv]
// Serial secondary port that turns frames into register reads and writes.
`timescale 1ns/1ps
`default_nettype none
module mac_spi_sec
    import mac_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic mosi,
    output logic miso,
    output logic miso_oe,
    output logic [5:0] rd_addr,
    input wire logic [15:0] rd_data,
    output logic wr_stb,
    output logic [5:0] wr_addr,
    output logic [15:0] wr_data
);

    logic sclk_q; // Previous clock level for edge detection.
    logic [4:0] bit_cnt_q; // Bits taken so far in this frame.
    logic [7:0] cmd_q; // Command byte, shifted in first.
    logic [15:0] din_q; // Write data, shifted in after the command.
    logic [15:0] dout_q; // Register value being shifted out.
    logic miso_q; // Output bit, changed on rising edges.
    logic wr_stb_q; // One-cycle write strobe.
    logic [15:0] wr_data_q; // Captured write word.

    // Edges of the serial clock; inputs are synchronous to clk.
    wire sclk_rise = sclk & ~sclk_q;
    wire sclk_fall = ~sclk & sclk_q;
    wire in_cmd = bit_cnt_q < MAC_CMD_BITS;
    wire in_data = (bit_cnt_q >= MAC_CMD_BITS) && (bit_cnt_q < MAC_FRAME_BITS);
    wire last_fall = sclk_fall && (bit_cnt_q == MAC_FRAME_BITS - 5'h01);
    wire cmd_done = sclk_fall && (bit_cnt_q == MAC_CMD_BITS - 5'h01);
    wire is_write = ~cmd_q[MAC_RW_BIT] & ~cmd_q[MAC_ZERO_BIT];

    // After seven command bits the address is complete in cmd_q[6:1].
    assign rd_addr = cmd_q[6:1];
    assign wr_addr = cmd_q[7:2];
    assign wr_data = wr_data_q;
    assign wr_stb = wr_stb_q;
    assign miso = miso_q;
    // The output drives only while the frame is selected.
    assign miso_oe = ~cs_n;

    // Frame shifter: sample on falling edges, present on rising edges.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclk_q <= 1'b0;
            bit_cnt_q <= 5'h00;
            cmd_q <= 8'h00;
            din_q <= 16'h0000;
            dout_q <= 16'h0000;
            miso_q <= 1'b0;
            wr_stb_q <= 1'b0;
            wr_data_q <= 16'h0000;
        end
        else
        begin
            sclk_q <= sclk;
            wr_stb_q <= 1'b0;
            if (cs_n)
            begin
                // Idle frame: restart the count and keep the output low.
                bit_cnt_q <= 5'h00;
                miso_q <= 1'b0;
            end
            else
            begin
                if (sclk_fall && in_cmd)
                    cmd_q <= {cmd_q[6:0], mosi};
                if (sclk_fall && in_data)
                    din_q <= {din_q[14:0], mosi};
                if (sclk_fall && bit_cnt_q < MAC_FRAME_BITS)
                    bit_cnt_q <= bit_cnt_q + 5'h01;
                // Old contents go out even on a write frame.
                if (cmd_done)
                    dout_q <= rd_data;
                if (sclk_rise)
                begin
                    miso_q <= in_data ? dout_q[15] : 1'b0;
                    if (in_data)
                        dout_q <= {dout_q[14:0], 1'b0};
                end
                // Extra clocks beyond the word are ignored.
                if (last_fall && is_write)
                begin
                    wr_stb_q <= 1'b1;
                    wr_data_q <= {din_q[14:0], mosi};
                end
            end
        end
    end

endmodule : mac_spi_sec
`default_nettype wire

// [rtl/mac_monitor_ctrl.sv]
// Configuration registers and conversion sequencer of the power monitor.
`timescale 1ns/1ps
`default_nettype none
module mac_monitor_ctrl
    import mac_pkg::*;
#(
    // Clock cycles per microsecond of conversion time; shrink for simulation.
    parameter int US_CYCLES = MAC_CLK_MHZ,
    // Clock cycles per start delay step; shrink for simulation.
    parameter int DELAY_STEP_CYCLES = MAC_DELAY_STEP_CYCLES
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    output logic conv_start,
    output logic [1:0] conv_channel,
    output logic conv_busy,
    output logic results_update,
    output logic accumulator_clear,
    output logic shunt_temp_comp_enable,
    output logic shunt_range_select,
    output logic shutdown
);

    logic [1:0] rst_sync_q; // Reset release synchroniser.
    logic rst_n; // Synchronised reset used by the whole design.
    logic soft_rst_q; // Pending soft reset, applied one cycle after the write.
    logic acc_clr_q; // One-cycle accumulator clear pulse.
    logic [9:0] gen_q; // Stored general bits 13 to 4.
    logic [15:0] cfg_q; // Converter configuration word.
    mac_state_t state_q; // Sequencer state.
    mac_state_t state_d; // Next sequencer state.
    logic [MAC_TMR_W-1:0] tmr_q; // Delay and conversion timer.
    logic [MAC_AVG_W-1:0] pass_q; // Averaging passes still to run.
    logic [1:0] chan_q; // Channel under conversion.
    logic start_q; // Conversions must (re)start, with the start delay.
    logic start_pls_q; // Conversion start strobe to the converter.
    logic upd_q; // Result update strobe.
    logic [5:0] rd_addr; // Read address from the serial port.
    logic wr_stb; // Write strobe from the serial port.
    logic [5:0] wr_addr; // Write address from the serial port.
    logic [15:0] wr_data; // Write data from the serial port.
    logic [15:0] rd_data; // Register read data.

    // Release reset through two flops so every flop leaves reset together.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            rst_sync_q <= 2'b00;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    // Serial port; it is not disturbed by a soft reset so the frame ends cleanly.
    mac_spi_sec u_spi (
        .clk(clk),
        .rst_n(rst_n),
        .cs_n(spi_cs_n),
        .sclk(spi_sclk),
        .mosi(spi_mosi),
        .miso(spi_miso),
        .miso_oe(spi_miso_oe),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .wr_stb(wr_stb),
        .wr_addr(wr_addr),
        .wr_data(wr_data)
    );

    // Register decode.
    wire wr_gen = wr_stb && (wr_addr == MAC_REG_GEN_CFG);
    wire wr_cfg = wr_stb && (wr_addr == MAC_REG_CONV_CFG);

    // Read view: reset and clear bits self-clear, low bits are zero.
    wire [15:0] gen_view = {1'b0, 1'b0, gen_q, MAC_LOW_ZERO};
    assign rd_data = (rd_addr == MAC_REG_GEN_CFG) ? gen_view :
                     (rd_addr == MAC_REG_CONV_CFG) ? cfg_q : 16'h0000;

    // Field decode of the stored words.
    wire [7:0] start_delay = gen_q[MAC_DELAY_MSB-MAC_STORED_LSB:MAC_DELAY_LSB-MAC_STORED_LSB];
    wire [3:0] mode = cfg_q[MAC_MODE_MSB:MAC_MODE_LSB];
    wire [2:0] chan_mask = mode[2:0];
    wire mode_off = (chan_mask == MAC_NO_CHANNELS);
    wire mode_cont = mode[MAC_CONT_BIT];
    wire [2:0] sample_average_count = cfg_q[MAC_AVG_MSB:MAC_AVG_LSB];
    wire [3:0] new_mode = wr_data[MAC_MODE_MSB:MAC_MODE_LSB];
    wire new_off = (new_mode[2:0] == MAC_NO_CHANNELS);

    assign shunt_temp_comp_enable = gen_q[MAC_COMP_BIT-MAC_STORED_LSB];
    assign shunt_range_select = gen_q[MAC_RANGE_BIT-MAC_STORED_LSB];

    // Conversion cycles per channel from its time code: bus, shunt, temperature.
    logic [MAC_TMR_W-1:0] ch_cycles [3];
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_ct
            wire [MAC_CT_W-1:0] ct_code = cfg_q[MAC_CT_LSB[gi] +: MAC_CT_W];
            // One shared table keeps the three fields consistent.
            assign ch_cycles[gi] = MAC_TMR_W'(MAC_CONV_TIME_US[ct_code] * US_CYCLES);
        end
    endgenerate

    // Delay before the first conversion, a product that fits the timer.
    wire [MAC_TMR_W-1:0] delay_cycles =
        MAC_TMR_W'(MAC_TMR_W'(start_delay) * MAC_TMR_W'(DELAY_STEP_CYCLES));
    wire [MAC_AVG_W-1:0] avg_passes = MAC_AVG_W'(MAC_AVG_SAMPLES[sample_average_count]);

    // Lowest enabled channel, and next enabled channel above the current one.
    wire [1:0] first_chan = chan_mask[0] ? 2'h0 : (chan_mask[1] ? 2'h1 : 2'h2);
    wire has_next = ((chan_q == 2'h0) && (chan_mask[1] || chan_mask[2])) ||
                    ((chan_q == 2'h1) && chan_mask[2]);
    wire [1:0] next_chan = ((chan_q == 2'h0) && chan_mask[1]) ? 2'h1 : 2'h2;
    wire tmr_zero = (tmr_q == '0);
    wire last_pass = (pass_q == MAC_AVG_W'(1));

    // Sequencer next state.
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            MAC_ST_IDLE:
            begin
                if (start_q && !mode_off)
                    state_d = MAC_ST_DELAY;
            end
            MAC_ST_DELAY:
            begin
                if (tmr_zero)
                    state_d = MAC_ST_CONV;
            end
            MAC_ST_CONV:
            begin
                if (tmr_zero && !has_next)
                    state_d = MAC_ST_DONE;
            end
            MAC_ST_DONE:
            begin
                // Single shot drops back to idle after the last pass; continuous keeps going.
                if (!last_pass || mode_cont)
                    state_d = MAC_ST_CONV;
                else
                    state_d = MAC_ST_IDLE;
            end
            default:
                state_d = MAC_ST_IDLE;
        endcase
    end

    // Configuration registers; a soft reset takes the same values as power-on.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            soft_rst_q <= 1'b0;
            acc_clr_q <= 1'b0;
            gen_q <= MAC_GEN_CFG_RST[MAC_STORED_MSB:MAC_STORED_LSB];
            cfg_q <= MAC_CONV_CFG_RST;
        end
        else if (soft_rst_q)
        begin
            soft_rst_q <= 1'b0;
            acc_clr_q <= 1'b0;
            gen_q <= MAC_GEN_CFG_RST[MAC_STORED_MSB:MAC_STORED_LSB];
            cfg_q <= MAC_CONV_CFG_RST;
        end
        else
        begin
            soft_rst_q <= wr_gen && wr_data[MAC_SOFT_RST_BIT];
            acc_clr_q <= wr_gen && wr_data[MAC_ACC_CLR_BIT];
            if (wr_gen)
                gen_q <= wr_data[MAC_STORED_MSB:MAC_STORED_LSB];
            if (wr_cfg)
                cfg_q <= wr_data;
        end
    end
    assign accumulator_clear = acc_clr_q;

    // Sequencer registers: timer, channel, averaging passes and strobes.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= MAC_ST_IDLE;
            tmr_q <= '0;
            pass_q <= '0;
            chan_q <= 2'd0;
            start_q <= 1'b1;
            start_pls_q <= 1'b0;
            upd_q <= 1'b0;
        end
        else if (soft_rst_q)
        begin
            // Back to the power-on picture, including the pending start.
            state_q <= MAC_ST_IDLE;
            tmr_q <= '0;
            pass_q <= '0;
            chan_q <= 2'd0;
            start_q <= 1'b1;
            start_pls_q <= 1'b0;
            upd_q <= 1'b0;
        end
        else if (wr_cfg)
        begin
            // Any mode write restarts; a shutdown code simply stops.
            state_q <= MAC_ST_IDLE;
            tmr_q <= '0;
            chan_q <= 2'd0;
            start_q <= !new_off;
            start_pls_q <= 1'b0;
            upd_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            start_pls_q <= 1'b0;
            upd_q <= 1'b0;
            case (state_q)
                MAC_ST_IDLE:
                begin
                    if (start_q && !mode_off)
                    begin
                        start_q <= 1'b0;
                        tmr_q <= delay_cycles;
                    end
                    chan_q <= first_chan;
                    pass_q <= avg_passes;
                end
                MAC_ST_DELAY:
                begin
                    if (tmr_zero)
                    begin
                        tmr_q <= ch_cycles[chan_q];
                        start_pls_q <= 1'b1;
                    end
                    else
                        tmr_q <= tmr_q - MAC_TMR_W'(1);
                end
                MAC_ST_CONV:
                begin
                    if (!tmr_zero)
                        tmr_q <= tmr_q - MAC_TMR_W'(1);
                    else if (has_next)
                    begin
                        chan_q <= next_chan;
                        tmr_q <= ch_cycles[next_chan];
                        start_pls_q <= 1'b1;
                    end
                end
                MAC_ST_DONE:
                begin
                    // Results publish only when a whole averaging run has finished.
                    upd_q <= last_pass;
                    pass_q <= last_pass ? avg_passes : pass_q - MAC_AVG_W'(1);
                    chan_q <= first_chan;
                    tmr_q <= ch_cycles[first_chan];
                    start_pls_q <= !last_pass || mode_cont;
                end
                default:
                    tmr_q <= '0;
            endcase
        end
    end

    // Status outputs.
    assign conv_start = start_pls_q;
    assign conv_channel = chan_q;
    assign conv_busy = (state_q == MAC_ST_CONV) || (state_q == MAC_ST_DONE);
    assign results_update = upd_q;
    assign shutdown = (state_q == MAC_ST_IDLE);

endmodule : mac_monitor_ctrl
`default_nettype wire

// [verif/mac_monitor_ctrl_monitor.sv]
// Concurrent property checks on the ports of the converter control block.
`timescale 1ns/1ps
`default_nettype none
module mac_ctrl_monitor
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic spi_mosi,
    input wire logic spi_miso,
    input wire logic spi_miso_oe,
    input wire logic conv_start,
    input wire logic [1:0] conv_channel,
    input wire logic conv_busy,
    input wire logic results_update,
    input wire logic accumulator_clear,
    input wire logic shunt_temp_comp_enable,
    input wire logic shunt_range_select,
    input wire logic shutdown
);
    // One clock domain, so the clock and the pin reset are given once here.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // The data pin is driven exactly while the frame select is low.
    a_oe_follows_select: assert property (spi_miso_oe == !spi_cs_n)
        else $error("miso enable differs from frame select");
    // A conversion start is a single-cycle pulse.
    a_start_one_cycle: assert property (conv_start |=> !conv_start)
        else $error("conversion start longer than one cycle");
    // A conversion starts only from the busy states.
    a_start_then_busy: assert property (conv_start |-> conv_busy)
        else $error("conversion start while not busy");
    // Only the bus, shunt and temperature channels exist.
    a_channel_legal: assert property (conv_start |-> conv_channel != 2'h3)
        else $error("conversion started on an unknown channel");
    // Result updates are single-cycle pulses that follow a busy cycle.
    a_update_after_busy: assert property (results_update |-> $past(conv_busy) ##1 !results_update)
        else $error("result update not a pulse after conversion");
    // The accumulator clear is a single-cycle pulse.
    a_clear_one_cycle: assert property (accumulator_clear |=> !accumulator_clear)
        else $error("accumulator clear longer than one cycle");
    // While shut down nothing converts.
    a_idle_not_busy: assert property (shutdown |-> !conv_busy)
        else $error("busy while shut down");
    // No conversion is started out of the idle state itself.
    a_idle_no_start: assert property (shutdown |-> !conv_start)
        else $error("conversion start while shut down");

    // Main scenarios: a temperature pass, a finished average, a clear.
    c_temp_start: cover property (conv_start && conv_channel == 2'h2);
    c_update: cover property (results_update);
    c_clear: cover property (accumulator_clear);
endmodule : mac_ctrl_monitor

bind mac_monitor_ctrl mac_ctrl_monitor u_ctrl_monitor (.clk(clk), .resetn(resetn),
    .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe), .conv_start(conv_start), .conv_channel(conv_channel),
    .conv_busy(conv_busy), .results_update(results_update),
    .accumulator_clear(accumulator_clear), .shunt_temp_comp_enable(shunt_temp_comp_enable),
    .shunt_range_select(shunt_range_select), .shutdown(shutdown));
`default_nettype wire

// [verif/tb.sv]
// Self-checking testbench of the monitor converter control block.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import mac_pkg::*;
    localparam int US_CYC = 1;
    localparam int STEP_CYC = 10;
    logic clk, resetn, spi_cs_n, spi_sclk, spi_mosi, spi_miso, spi_miso_oe;
    logic conv_start, conv_busy, results_update, accumulator_clear, shutdown;
    logic shunt_temp_comp_enable, shunt_range_select;
    logic [1:0] conv_channel;
    logic [1:0] chans[$]; // Channels of observed starts, in order.
    int errors, checks_done, cyc, starts_n, upd_n, clr_n;

    mac_monitor_ctrl #(.US_CYCLES(US_CYC), .DELAY_STEP_CYCLES(STEP_CYC)) DUT (.clk(clk),
        .resetn(resetn), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi),
        .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .conv_start(conv_start),
        .conv_channel(conv_channel), .conv_busy(conv_busy), .results_update(results_update),
        .accumulator_clear(accumulator_clear), .shunt_temp_comp_enable(shunt_temp_comp_enable),
        .shunt_range_select(shunt_range_select), .shutdown(shutdown));

    // Free-running 50 MHz clock.
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Pulse collector; it reads the registered outputs before they update.
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (conv_start === 1'b1)
            chans.push_back(conv_channel);
        starts_n <= starts_n + int'(conv_start === 1'b1);
        upd_n <= upd_n + int'(results_update === 1'b1);
        clr_n <= clr_n + int'(accumulator_clear === 1'b1);
    end

    task automatic check(input logic [15:0] exp, input logic [15:0] got, input string what);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("FAIL %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    // One whole 24-bit frame; sclk idles low, each half period lasts three cycles.
    task automatic xfer(input logic [7:0] cmd, input logic [15:0] wdat, output logic [15:0] rdat);
        logic [23:0] sh;
        sh = {cmd, wdat};
        rdat = 16'h0000;
        spi_cs_n = 1'b0;
        repeat (3) @(negedge clk);
        for (int i = 23; i >= 0; i--)
        begin
            spi_mosi = sh[i];
            spi_sclk = 1'b1;
            repeat (3) @(negedge clk);
            if (i < 16)
                rdat = {rdat[14:0], spi_miso};
            spi_sclk = 1'b0;
            repeat (3) @(negedge clk);
        end
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
        repeat (4) @(negedge clk);
    endtask : xfer

    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        logic [15:0] r;
        xfer({a, 2'b00}, d, r);
    endtask : wr

    task automatic rd(input logic [5:0] a, output logic [15:0] d);
        xfer({a, 2'b01}, 16'h0000, d);
    endtask : rd

    // Bounded wait for the next start pulse; returns its cycle number.
    task automatic wait_start(input int limit, output int t);
        int n;
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end while (conv_start !== 1'b1 && n < limit);
        check(16'h0001, 16'(n < limit), "conversion start seen");
        t = cyc;
    endtask : wait_start

    // Start-to-start interval of a continuous configuration, after a restart.
    task automatic period(input logic [15:0] cfg, output int p);
        int t1, t2;
        wr(MAC_REG_CONV_CFG, cfg);
        wait_start(6000, t1);
        wait_start(6000, t1);
        wait_start(6000, t2);
        p = t2 - t1;
    endtask : period

    task automatic test_reset_values();
        logic [15:0] r;
        int t;
        rd(MAC_REG_GEN_CFG, r);
        check(16'h0000, r, "general reset value");
        rd(MAC_REG_CONV_CFG, r);
        check(16'hfb68, r, "converter reset value");
        wait_start(3000, t);
        check(16'h0001, 16'(conv_channel), "next channel in mode f");
    endtask : test_reset_values

    task automatic test_gen_fields();
        logic [15:0] r;
        wr(MAC_REG_GEN_CFG, 16'h3fff);
        rd(MAC_REG_GEN_CFG, r);
        check(16'h3ff0, r, "general readback");
        check(16'h0001, 16'(shunt_temp_comp_enable), "compensation on");
        check(16'h0001, 16'(shunt_range_select), "narrow range");
        wr(MAC_REG_GEN_CFG, 16'h0010);
        check(16'h0000, 16'(shunt_temp_comp_enable), "compensation off");
        clr_n = 0;
        wr(MAC_REG_GEN_CFG, 16'h4020);
        check(16'h0001, 16'(clr_n), "one accumulator clear");
        rd(MAC_REG_GEN_CFG, r);
        check(16'h0020, r, "clear leaves fields");
        check(16'h0000, 16'(shunt_range_select), "wide range");
        wr(6'h02, 16'hffff);
        rd(6'h02, r);
        check(16'h0000, r, "unmapped address");
        xfer({MAC_REG_CONV_CFG, 2'b10}, 16'h0000, r);
        rd(MAC_REG_CONV_CFG, r);
        check(16'hfb68, r, "malformed command ignored");
        wr(MAC_REG_GEN_CFG, 16'h0000);
    endtask : test_gen_fields

    // Both shutdown codes stop all conversions.
    task automatic test_shutdown();
        for (int i = 0; i < 2; i++)
        begin
            wr(MAC_REG_CONV_CFG, {(i == 0) ? 4'h0 : 4'h8, 12'h000});
            chans.delete();
            repeat (300) @(negedge clk);
            check(16'h0001, 16'(shutdown), "shut down");
            check(16'h0000, 16'(chans.size()), "no starts in shutdown");
        end
    endtask : test_shutdown

    // Every single-shot code: channel order, one update, then back to shutdown.
    task automatic test_single_shot();
        logic [3:0] m;
        int n;
        for (int mi = 1; mi < 8; mi++)
        begin
            m = 4'(mi);
            chans.delete();
            upd_n = 0;
            wr(MAC_REG_CONV_CFG, {m, 12'h000});
            repeat (600) @(negedge clk);
            n = 0;
            for (int ch = 0; ch < 3; ch++)
                if (m[ch])
                begin
                    check(16'(ch), (n < chans.size()) ? 16'(chans[n]) : 16'hffff, "order");
                    n++;
                end
            check(16'(n), 16'(chans.size()), "single-shot starts");
            check(16'h0001, 16'(upd_n), "single-shot update");
            check(16'h0001, 16'(shutdown), "back to shutdown");
        end
    endtask : test_single_shot

    // Starts counted between two result updates match the averaging count.
    task automatic test_average();
        for (int c = 0; c < 3; c++)
        begin
            wr(MAC_REG_CONV_CFG, 16'h9000 | 16'(c));
            upd_n = 0;
            while (upd_n == 0)
                @(negedge clk);
            starts_n = 0;
            upd_n = 0;
            while (upd_n == 0 && starts_n < 40)
                @(negedge clk);
            check(16'(MAC_AVG_SAMPLES[c]), 16'(starts_n), "passes per update");
        end
    endtask : test_average

    // Longest start delay against none, whose first start the frame hides.
    task automatic test_delay();
        int e, ta, tb2, p0, d0;
        wr(MAC_REG_CONV_CFG, 16'h9000);
        e = cyc;
        wait_start(3000, ta);
        wait_start(3000, tb2);
        d0 = ta - e;
        p0 = tb2 - ta;
        wr(MAC_REG_GEN_CFG, 16'h3fc0);
        wr(MAC_REG_CONV_CFG, 16'h9000);
        e = cyc;
        wait_start(4000, ta);
        wait_start(4000, tb2);
        check(16'(255 * STEP_CYC), 16'(ta - e - d0 + p0), "maximum start delay");
        check(16'(p0), 16'(tb2 - ta), "no delay between passes");
        wr(MAC_REG_GEN_CFG, 16'h0000);
    endtask : test_delay

    // Conversion time codes, seen as the growth of the continuous period.
    task automatic test_conv_time();
        logic [3:0] m;
        int base, p;
        for (int ch = 0; ch < 3; ch++)
        begin
            m = 4'h8 | (4'h1 << ch);
            period({m, 12'h000}, base);
            for (int k = 1; k < 8; k++)
                if (ch == 0 || k == 7)
                begin
                    period({m, 12'h000} | (16'(k) << MAC_CT_LSB[ch]), p);
                    check(16'((MAC_CONV_TIME_US[k] - MAC_CONV_TIME_US[0]) * US_CYC),
                        16'(p - base), "conversion time");
                end
        end
    endtask : test_conv_time

    task automatic test_soft_reset();
        logic [15:0] r;
        wr(MAC_REG_GEN_CFG, 16'h0030);
        wr(MAC_REG_CONV_CFG, 16'h1249);
        wr(MAC_REG_GEN_CFG, 16'h8030);
        rd(MAC_REG_GEN_CFG, r);
        check(16'h0000, r, "general after soft reset");
        rd(MAC_REG_CONV_CFG, r);
        check(16'hfb68, r, "converter after soft reset");
        check(16'h0000, 16'(shunt_range_select), "range after soft reset");
    endtask : test_soft_reset

    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    // Main sequence: three cycles of reset, then the scenarios.
    initial
    begin
        resetn = 1'b0;
        spi_cs_n = 1'b1;
        spi_sclk = 1'b0;
        spi_mosi = 1'b0;
        {errors, checks_done, cyc, starts_n, upd_n, clr_n} = '0;
        repeat (3) @(negedge clk);
        resetn = 1'b1;
        repeat (4) @(negedge clk);
        test_reset_values();
        test_gen_fields();
        test_shutdown();
        test_single_shot();
        test_average();
        test_delay();
        test_conv_time();
        test_soft_reset();
        print_verdict();
    end

    // Watchdog: about 100000 cycles, well beyond the expected run.
    initial
    begin
        #2000000;
        errors++;
        $display("FAIL %0t watchdog expired", $time);
        print_verdict();
    end
endmodule : tb
`default_nettype wire
